// File: include/vrr_pkg.sv
`default_nettype none
package vrr_pkg;
    localparam int AW = 8;
    localparam int LANES = 8;
    localparam int PAIR_WORDS = 4;
    localparam int CMD_W = 11;
    // Word indices; byte address is four times the index
    localparam logic [5:0] IDX_CMD = 6'h00;
    localparam logic [5:0] IDX_OPND = 6'h01;
    localparam logic [5:0] IDX_DST = 6'h05;
    localparam logic [5:0] IDX_ACC_SEL = 6'h09;
    localparam logic [5:0] IDX_ACC_LO = 6'h0a;
    localparam logic [5:0] IDX_ACC_HI = 6'h0b;
    localparam logic [5:0] IDX_DIV_OUT = 6'h0c;
    localparam logic [5:0] IDX_DIV_IN = 6'h0d;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RECIP_ZERO = 32'h7fffffff;
    localparam logic [4:0] LSH_ZERO_SINGLE = 5'h10;
    localparam logic [4:0] LSH_ZERO_LOW = 5'h00;
    localparam logic [15:0] S16_MAX = 16'h7fff;
    localparam logic [15:0] S16_MIN = 16'h8000;
    typedef enum logic [2:0] {
        OP_IDLE = 3'h0,
        OP_RECIP = 3'h1,
        OP_RCPH = 3'h2,
        OP_RCPL = 3'h3,
        OP_RNDN = 3'h4,
        OP_RNDP = 3'h5
    } vrr_op_e;
    typedef struct packed {
        logic addend_up;
        logic [2:0] de;
        logic [3:0] e;
        vrr_op_e op;
    } vrr_cmd_s;
endpackage : vrr_pkg
`default_nettype wire

// File: hdl/vrr_unit.sv
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Single reciprocal of element e; low half to destination element de
// - High op writes upper half of held result, no new calculation
// - High op latches element into upper half of divider input, low zero
// - Low op joins held upper half with element, computes, writes low half
// - Single and low ops keep full 32-bit result in result register
// - Zero source element forces result to 7fffffff
// - Negative source: magnitude as single-op input (low op uses element as is), result negated afterwards
// - Normalise by left shift, table index, shift right by complement
// - Zero input: shift 16 for single op, 0 for low op
// - Select bit set moves addend up 16, else sign-extends it
// - Negative rounding adds only to negative lanes, clamps middle half
// - Positive rounding adds only to non-negative lanes, clamps middle half
// - Element field picks second-operand lane: same, pair, quad, broadcast
module vrr_unit
    import vrr_pkg::*;
#(
    parameter logic [1023:0][15:0] RECIP_TABLE = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    function automatic logic [31:0] merge(
        input logic [31:0] o,
        input logic [31:0] n,
        input logic [3:0] s
    );
        for (int b = 0; b < 4; b++) begin
            merge[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
        end
    endfunction : merge

    function automatic logic [2:0] lane_sel(
        input logic [2:0] i,
        input logic [3:0] e
    );
        if (e[3]) begin
            lane_sel = e[2:0];
        end else if (e[2]) begin
            lane_sel = {i[2], e[1:0]};
        end else if (e[1]) begin
            lane_sel = {i[2:1], e[0]};
        end else begin
            lane_sel = i;
        end
    endfunction : lane_sel

    function automatic logic [15:0] clamp16(input logic [47:0] a);
        if (&a[47:31] || ~|a[47:31]) begin
            clamp16 = a[31:16];
        end else begin
            clamp16 = a[47] ? S16_MIN : S16_MAX;
        end
    endfunction : clamp16

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic aw_full, next_aw_full;
    logic w_full, next_w_full;
    logic [AW-1:0] wa, next_wa;
    logic [31:0] wd, next_wd;
    logic [3:0] ws, next_ws;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [15:0] opnd [LANES];
    logic [15:0] next_opnd [LANES];
    logic [15:0] dst [LANES];
    logic [15:0] next_dst [LANES];
    logic [47:0] acc [LANES];
    logic [47:0] next_acc [LANES];
    logic [31:0] div_in, next_div_in;
    logic [31:0] div_out, next_div_out;
    logic [2:0] acc_sel, next_acc_sel;
    logic [CMD_W-1:0] last_cmd, next_last_cmd;

    logic [5:0] wi, ri;
    logic do_wr, ex, wr_hit, rd_hit;
    logic [31:0] rd_data, wm;
    vrr_cmd_s c;
    logic [15:0] src, mag, rom;
    logic [31:0] din, shifted, raw, recip;
    logic [4:0] lsh;
    logic [9:0] addr;

    assign wi = wa[AW-1:2];
    assign ri = s_axi_araddr[AW-1:2];
    assign do_wr = aw_full && w_full && !s_axi_bvalid;
    assign ex = do_wr && ce && (wi == IDX_CMD);

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    always_comb begin
        wm = '0;
        c = vrr_cmd_s'(last_cmd);
        wr_hit = (wi == IDX_CMD) || (wi == IDX_ACC_SEL)
            || (wi == IDX_ACC_LO) || (wi == IDX_ACC_HI);
        rd_hit = (ri <= IDX_DIV_IN);
        rd_data = '0;
        case (ri)
            IDX_CMD: rd_data = {{(32-CMD_W){1'b0}}, last_cmd};
            IDX_ACC_SEL: rd_data = {29'h0, acc_sel};
            IDX_ACC_LO: rd_data = acc[acc_sel][31:0];
            IDX_ACC_HI: rd_data = {16'h0, acc[acc_sel][47:32]};
            IDX_DIV_OUT: rd_data = div_out;
            IDX_DIV_IN: rd_data = div_in;
            default: rd_data = '0;
        endcase
        for (int k = 0; k < PAIR_WORDS; k++) begin
            if (wi == 6'(IDX_OPND + k)) begin
                wr_hit = 1'b1;
            end
            if (ri == 6'(IDX_OPND + k)) begin
                rd_data = {opnd[2*k+1], opnd[2*k]};
            end
            if (ri == 6'(IDX_DST + k)) begin
                rd_data = {dst[2*k+1], dst[2*k]};
            end
        end
        if (wi == IDX_CMD) begin
            wm = merge({{(32-CMD_W){1'b0}}, last_cmd}, wd, ws);
            c = vrr_cmd_s'(wm[CMD_W-1:0]);
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_wa = wa;
        next_wd = wd;
        next_ws = ws;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_wa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_wd = s_axi_wdata;
            next_ws = s_axi_wstrb;
        end
        if (do_wr) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = rd_data;
            next_rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        next_awready = !next_aw_full;
        next_wready = !next_w_full;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            wa <= '0;
            wd <= '0;
            ws <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= '0;
        end else if (ce) begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            wa <= next_wa;
            wd <= next_wd;
            ws <= next_ws;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // Reciprocal path
    // ----------------------------------------
    always_comb begin
        src = opnd[c.e[2:0]];
        mag = src[15] ? 16'(-src) : src;
        din = (c.op == OP_RCPL) ? {div_in[31:16], src} : {16'h0, mag};
        lsh = (c.op == OP_RCPL) ? LSH_ZERO_LOW : LSH_ZERO_SINGLE;
        for (int i = 0; i < 32; i++) begin
            if (din[i]) begin
                lsh = 5'(31 - i);
            end
        end
        shifted = din << lsh;
        addr = shifted[31:22];
        rom = RECIP_TABLE[addr];
        raw = {2'b01, rom, 14'h0} >> (~lsh);
        recip = src[15] ? 32'(-raw) : raw;
        if (src == 16'h0) begin
            recip = RECIP_ZERO;
        end
    end

    // ----------------------------------------
    // Datapath state
    // ----------------------------------------
    always_comb begin
        logic [2:0] j;
        logic [31:0] add;
        logic [47:0] sum;
        logic [31:0] mw;
        j = '0;
        add = '0;
        sum = '0;
        mw = '0;
        next_opnd = opnd;
        next_dst = dst;
        next_acc = acc;
        next_div_in = div_in;
        next_div_out = div_out;
        next_acc_sel = acc_sel;
        next_last_cmd = last_cmd;
        if (do_wr) begin
            for (int k = 0; k < PAIR_WORDS; k++) begin
                if (wi == 6'(IDX_OPND + k)) begin
                    {next_opnd[2*k+1], next_opnd[2*k]} = merge({opnd[2*k+1], opnd[2*k]}, wd, ws);
                end
            end
            if (wi == IDX_ACC_SEL) begin
                mw = merge({29'h0, acc_sel}, wd, ws);
                next_acc_sel = mw[2:0];
            end
            if (wi == IDX_ACC_LO) begin
                next_acc[acc_sel][31:0] = merge(acc[acc_sel][31:0], wd, ws);
            end
            if (wi == IDX_ACC_HI) begin
                mw = merge({16'h0, acc[acc_sel][47:32]}, wd, ws);
                next_acc[acc_sel][47:32] = mw[15:0];
            end
        end
        if (ex) begin
            next_last_cmd = c;
            case (c.op)
                OP_RECIP, OP_RCPL: begin
                    next_div_in = din;
                    next_div_out = recip;
                    next_dst[c.de] = recip[15:0];
                end
                OP_RCPH: begin
                    next_dst[c.de] = div_out[31:16];
                    next_div_in = {src, 16'h0};
                end
                OP_RNDN, OP_RNDP: begin
                    for (int i = 0; i < LANES; i++) begin
                        j = lane_sel(3'(i), c.e);
                        add = c.addend_up ? {opnd[j], 16'h0} : {{16{opnd[j][15]}}, opnd[j]};
                        sum = acc[i] + {{16{add[31]}}, add};
                        if (acc[i][47] == (c.op == OP_RNDN)) begin
                            next_acc[i] = sum;
                        end
                        next_dst[i] = clamp16(next_acc[i]);
                    end
                end
                default: begin
                end
            endcase
            if (c.op == OP_RECIP || c.op == OP_RCPH || c.op == OP_RCPL) begin
                for (int i = 0; i < LANES; i++) begin
                    next_acc[i][15:0] = src;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opnd <= '{default: '0};
            dst <= '{default: '0};
            acc <= '{default: '0};
            div_in <= '0;
            div_out <= '0;
            acc_sel <= '0;
            last_cmd <= '0;
        end else if (ce) begin
            opnd <= next_opnd;
            dst <= next_dst;
            acc <= next_acc;
            div_in <= next_div_in;
            div_out <= next_div_out;
            acc_sel <= next_acc_sel;
            last_cmd <= next_last_cmd;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_single_low;
        ex && c.op == OP_RECIP |=> dst[$past(c.de)] == $past(recip[15:0]);
    endproperty
    a_single_low: assert property (p_single_low) else $error("low half not written");

    property p_high_out;
        ex && c.op == OP_RCPH |=> dst[$past(c.de)] == $past(div_out[31:16]) && $stable(div_out);
    endproperty
    a_high_out: assert property (p_high_out) else $error("high half wrong");

    property p_high_in;
        ex && c.op == OP_RCPH |=> div_in == {$past(src), 16'h0};
    endproperty
    a_high_in: assert property (p_high_in) else $error("upper input not latched");

    property p_low_in;
        ex && c.op == OP_RCPL |=> div_in == {$past(div_in[31:16]), $past(src)} && div_out == $past(recip);
    endproperty
    a_low_in: assert property (p_low_in) else $error("low op input wrong");

    property p_zero_src;
        ex && c.op != OP_RCPH && c.op[2] == 1'b0 && c.op != OP_IDLE && src == 16'h0 |=> div_out == RECIP_ZERO;
    endproperty
    a_zero_src: assert property (p_zero_src) else $error("zero source not saturated");

    property p_neg_src;
        ex && c.op == OP_RECIP && src[15] |=> div_out == 32'(-$past(raw));
    endproperty
    a_neg_src: assert property (p_neg_src) else $error("negative result not negated");

    property p_zero_shift;
        ex && din == 32'h0 |-> lsh == ((c.op == OP_RCPL) ? LSH_ZERO_LOW : LSH_ZERO_SINGLE);
    endproperty
    a_zero_shift: assert property (p_zero_shift) else $error("zero input shift wrong");

    property p_acc_copy;
        ex && (c.op == OP_RECIP || c.op == OP_RCPH || c.op == OP_RCPL)
            |=> acc[7] == {$past(acc[7][47:16]), $past(src)};
    endproperty
    a_acc_copy: assert property (p_acc_copy) else $error("lane not loaded");

    property p_rndn_skip;
        ex && c.op == OP_RNDN && !acc[0][47] |=> acc[0] == $past(acc[0]);
    endproperty
    a_rndn_skip: assert property (p_rndn_skip) else $error("non-negative lane changed");

    property p_rndp_skip;
        ex && c.op == OP_RNDP && acc[1][47] |=> acc[1] == $past(acc[1]);
    endproperty
    a_rndp_skip: assert property (p_rndp_skip) else $error("negative lane changed");

    property p_cov_dbl;
        ex && c.op == OP_RCPH ##[1:20] ex && c.op == OP_RCPL;
    endproperty
    c_cov_dbl: cover property (p_cov_dbl);
    property p_cov_rndn;
        ex && c.op == OP_RNDN && acc[1][47];
    endproperty
    c_cov_rndn: cover property (p_cov_rndn);
    property p_cov_rndp;
        ex && c.op == OP_RNDP && c.addend_up;
    endproperty
    c_cov_rndp: cover property (p_cov_rndp);

endmodule : vrr_unit
`default_nettype wire

// File: tb/vrr_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module vrr_host_model
    import vrr_pkg::*;
(
    input wire logic aclk,
    output logic [AW-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [AW-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // Response readies stay high, so every answer is taken at once
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end

    // ----------------------------------------
    // Bus cycles, entered just after an edge
    // ----------------------------------------
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
endmodule : vrr_host_model
`default_nettype wire

// File: tb/vrr_unit_test.sv
`timescale 1ns/1ns
`default_nettype none
module vrr_unit_test
    import vrr_pkg::*;
;
    function automatic logic [1023:0][15:0] mk_tbl();
        for (int k = 0; k < 1024; k++) begin
            mk_tbl[k] = 16'(k) ^ 16'h5a3c;
        end
    endfunction : mk_tbl
    localparam logic [1023:0][15:0] TBL = mk_tbl();
    typedef struct packed {logic [15:0] src; logic [3:0] e; logic [2:0] de;} vrr_row_s;
    localparam vrr_row_s ROWS [8] = '{'{16'h0001, 4'h1, 3'h0}, '{16'h0000, 4'h2, 3'h3}, '{16'hffff, 4'h3, 3'h7},
        '{16'h8000, 4'h4, 3'h1}, '{16'h1234, 4'h5, 3'h2}, '{16'h7fff, 4'h6, 3'h5}, '{16'hc001, 4'h7, 3'h4},
        '{16'h0100, 4'h8, 3'h6}};
    localparam logic [47:0] ACC0 [8] = '{48'h000000010000, 48'hffffffff0000, 48'h00007fff0000, 48'hffff80000000,
        48'h0, 48'h7fff00000000, 48'h800000000000, 48'hfffffffffff0};
    localparam logic [15:0] OPND0 [8] = '{16'h0001, 16'hffff, 16'h7fff, 16'h8000, 16'h1234, 16'h0010, 16'hfedc, 16'h4000};
    localparam logic [3:0] EL [5] = '{4'h0, 4'h1, 4'h3, 4'h6, 4'hb};
    localparam logic [5:0] RST_IDX [6] = '{IDX_CMD, IDX_OPND, IDX_DST, IDX_ACC_LO, IDX_DIV_OUT, IDX_DIV_IN};

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [15:0] vm [8];
    logic [15:0] dm [8];
    logic [47:0] am [8];
    logic [31:0] dout, din;

    always #5 aclk = ~aclk;

    vrr_unit #(.RECIP_TABLE(TBL)) i_vrr_unit (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    vrr_host_model i_vrr_host_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // ----------------------------------------
    // Reference model and helpers
    // ----------------------------------------
    function automatic logic [31:0] recip_exp(input logic [31:0] d, input logic [15:0] src);
        logic [4:0] lsh;
        logic [31:0] n;
        logic [31:0] res;
        lsh = 5'h0;
        for (int b = 0; b < 32; b++) begin
            if (d[b]) begin
                lsh = 5'(31 - b);
            end
        end
        n = d << lsh;
        res = {2'b01, TBL[n[31:22]], 14'h0} >> (~lsh);
        if (src[15]) begin
            res = -res;
        end
        return (src == 16'h0) ? 32'h7fffffff : res;
    endfunction : recip_exp

    function automatic logic [2:0] jsel(input logic [3:0] e, input logic [2:0] i);
        if (e[3]) return e[2:0];
        if (e[3:2] == 2'b01) return {i[2], e[1:0]};
        if (e[3:1] == 3'b001) return {i[2:1], e[0]};
        return i;
    endfunction : jsel

    function automatic logic [15:0] clamp(input logic [31:0] v);
        if ($signed(v) > 32'sh7fff) return 16'h7fff;
        if ($signed(v) < -32'sh8000) return 16'h8000;
        return v[15:0];
    endfunction : clamp

    function automatic logic [AW-1:0] adr(input logic [5:0] i);
        return {i, 2'b00};
    endfunction : adr

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic wreg(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        i_vrr_host_model.wr(adr(i), d, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wreg

    task automatic rchk(input logic [5:0] i, input logic [31:0] ed, input logic [1:0] er, input string nm);
        logic [31:0] d;
        logic [1:0] r;
        i_vrr_host_model.rd(adr(i), d, r);
        chk(nm, ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rchk

    task automatic set_opnd();
        for (int k = 0; k < 4; k++) wreg(IDX_OPND + 6'(k), {vm[2*k+1], vm[2*k]}, RESP_OKAY);
    endtask : set_opnd

    task automatic chk_all();
        for (int k = 0; k < 4; k++) rchk(IDX_DST + 6'(k), {dm[2*k+1], dm[2*k]}, RESP_OKAY, "dst");
        rchk(IDX_DIV_OUT, dout, RESP_OKAY, "div_out");
        rchk(IDX_DIV_IN, din, RESP_OKAY, "div_in");
    endtask : chk_all

    task automatic set_acc(input int i, input logic [47:0] v);
        wreg(IDX_ACC_SEL, 32'(i), RESP_OKAY);
        wreg(IDX_ACC_LO, v[31:0], RESP_OKAY);
        wreg(IDX_ACC_HI, {16'h0, v[47:32]}, RESP_OKAY);
        am[i] = v;
    endtask : set_acc

    task automatic chk_acc(input int i);
        wreg(IDX_ACC_SEL, 32'(i), RESP_OKAY);
        rchk(IDX_ACC_LO, am[i][31:0], RESP_OKAY, "acc_lo");
        rchk(IDX_ACC_HI, {16'h0, am[i][47:32]}, RESP_OKAY, "acc_hi");
    endtask : chk_acc

    task automatic run(input vrr_op_e op, input logic [3:0] e, input logic [2:0] de, input logic up);
        logic [15:0] s;
        logic [47:0] ad;
        logic [2:0] j;
        s = vm[e[2:0]];
        case (op)
            OP_RECIP: begin
                din = {16'h0, s[15] ? -s : s};
                dout = recip_exp(din, s);
                dm[de] = dout[15:0];
            end
            OP_RCPH: begin
                dm[de] = dout[31:16];
                din = {s, 16'h0};
            end
            OP_RCPL: begin
                din = {din[31:16], s};
                dout = recip_exp(din, s);
                dm[de] = dout[15:0];
            end
            default: begin
                for (int i = 0; i < 8; i++) begin
                    j = jsel(e, 3'(i));
                    ad = up ? {{16{vm[j][15]}}, vm[j], 16'h0} : {{32{vm[j][15]}}, vm[j]};
                    if (am[i][47] == (op == OP_RNDN)) begin
                        am[i] = am[i] + ad;
                    end
                    dm[i] = clamp(am[i][47:16]);
                end
            end
        endcase
        if (op inside {OP_RECIP, OP_RCPH, OP_RCPL}) begin
            for (int i = 0; i < 8; i++) am[i][15:0] = s;
        end
        wreg(IDX_CMD, {21'h0, up, de, e, op}, RESP_OKAY);
        chk_all();
    endtask : run

    task automatic conclude();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) begin
            {vm[i], dm[i], am[i]} = '0;
        end
        {din, dout} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (RST_IDX[k]) rchk(RST_IDX[k], 32'h0, RESP_OKAY, "reset");
        foreach (ROWS[r]) begin
            vm[ROWS[r].e[2:0]] = ROWS[r].src;
            set_opnd();
            run(OP_RECIP, ROWS[r].e, ROWS[r].de, 1'b0);
        end
        set_acc(3, 48'h123456789abc);
        vm[2] = 16'h4321;
        set_opnd();
        run(OP_RECIP, 4'h2, 3'h3, 1'b0);
        chk_acc(3);
        {vm[0], vm[1], vm[5]} = {16'h0003, 16'h8421, 16'h0000};
        set_opnd();
        run(OP_RCPH, 4'h0, 3'h6, 1'b0);
        run(OP_RCPL, 4'h1, 3'h7, 1'b0);
        run(OP_RCPH, 4'h5, 3'h2, 1'b0);
        run(OP_RCPL, 4'h5, 3'h4, 1'b0);
        wreg(IDX_DST, 32'hdeadbeef, RESP_SLVERR);
        wreg(IDX_DIV_OUT, 32'h12345678, RESP_SLVERR);
        wreg(6'h3f, 32'h5555aaaa, RESP_SLVERR);
        rchk(6'h0e, 32'h0, RESP_SLVERR, "unmapped");
        chk_all();
        foreach (ACC0[i]) begin
            set_acc(i, ACC0[i]);
            vm[i] = OPND0[i];
        end
        set_opnd();
        foreach (EL[k]) begin
            for (int v = 0; v < 2; v++) begin
                run(OP_RNDN, EL[k], 3'h0, v[0]);
                run(OP_RNDP, EL[k], 3'h0, v[0]);
            end
        end
        chk_acc(0);
        chk_acc(7);
        // Reset in mid-run clears every register again
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (RST_IDX[k]) rchk(RST_IDX[k], 32'h0, RESP_OKAY, "reset_mid");
        conclude();
    end
endmodule : vrr_unit_test
`default_nettype wire
